// ==== smc_pkg.sv ====
// stop-mode controller constants, types and pin synchroniser
// Contract
// R01 - plain stop3 halts clocks and oscillator, clock generator standby, converter off, regulator standby
// R02 - stop3 keeps registers, logic and RAM; pins held by retained logic
// R03 - stop3 exits on reset pin, interrupt or keypad pins, or periodic wake
// R04 - reset pin exit fetches reset vector; interrupt exits fetch their own vector
// R05 - periodic wake source off and unable to wake when rate bits are zero
// R06 - debug enable at stop keeps debug clocks and full regulation
// R07 - stop1 or stop2 request with debug enable enters stop3 instead
// R08 - status memory commands refused with stop/wait error while stopped
// R09 - background command wakes debug-enabled stop into active debug mode
// R10 - debug stop3 keeps clock generator and regulator active, converter off
// R11 - both detect enables set at stop keep regulator active
// R12 - stop1 or stop2 request with detect-in-stop set enters stop3 instead
// R13 - detect stop3: clock generator standby, regulator active, converter off, pins held
// R14 - every stop mode stops peripheral clocks, even with debug clocks running
// R15 - stop2 latches pins before entry; stop1 forces pins to reset defaults
// R16 - stop2 wake resets registers, keeps RAM, pins latched until acknowledge
// R17 - stop1 wake resets registers, RAM not kept; program memory always kept
// R18 - stop3 clock generator standby with optional oscillator; off in stop1, stop2
// R19 - stop halts timer and serial units; reset after stop1 or stop2 wake
// R20 - converter in standby during stop; reset after stop1 or stop2 wake
// R21 - keypad pins wake stop3; keypad disabled in stop1, stop2, reset after
// R22 - regulator standby in stop unless detect-in-stop or debug enabled
// R23 - stop with entry enable clear forces illegal-opcode reset instead
// R24 - power-down 1 with partial 0 is stop1, 1/1 stop2, 0 stop3
// R25 - stop2 wake sets recovery flag, held until acknowledge written one
// R26 - stop mode resolved in one cycle, overrides beating requested depth
`timescale 1ns/1ps

package smc_pkg;
  localparam int SMC_AW = 4;
  localparam int SMC_DW = 16;
  localparam int SMC_KBI_W = 8;
  localparam logic [3:0] SMC_OFS_CTRL = 4'h0;
  localparam logic [3:0] SMC_OFS_KBI_EN = 4'h1;
  localparam logic [3:0] SMC_OFS_STATUS = 4'h2;
  localparam logic [3:0] SMC_OFS_ACK = 4'h3;
  localparam int SMC_C_STOP_ENTRY_ENABLE = 0;
  localparam int SMC_C_PDC = 1;
  localparam int SMC_C_PARTIAL_POWER_DOWN_SELECT = 2;
  localparam int SMC_C_DBG = 3;
  localparam int SMC_C_LOW_VOLT_DETECT_ENABLE = 4;
  localparam int SMC_C_LOW_VOLT_DETECT_IN_STOP_ENABLE = 5;
  localparam int SMC_C_RTI_LO = 6;
  localparam int SMC_C_RTI_MID = 7;
  localparam int SMC_C_RTI_HI = 8;
  localparam int SMC_C_KEEP_OSC = 9;
  localparam int SMC_S_MODE = 0;
  localparam int SMC_S_FLAG = 3;
  localparam int SMC_S_LATCH = 4;
  localparam int SMC_S_VEC = 5;
  localparam int SMC_A_ACK = 0;
  localparam logic [15:0] SMC_CTRL_RST = 16'h0000;
  localparam logic [15:0] SMC_KBI_RST = 16'h0000;
  // pins idle high, tick line idle low
  localparam logic [10:0] SMC_SYNC_RST = 11'h3ff;

  typedef enum logic [2:0] {
    SMC_RUN, SMC_STOP1, SMC_STOP2, SMC_STOP3, SMC_DEBUG
  } smc_state_e;

  typedef enum logic [2:0] {
    SMC_V_NONE, SMC_V_RESET, SMC_V_IRQ, SMC_V_KBI, SMC_V_RTI, SMC_V_DEBUG
  } smc_vec_e;

  typedef struct packed {
    logic [SMC_AW-1:0] addr;
    logic [SMC_DW-1:0] wdata;
    logic wr;
    logic rd;
  } smc_bus_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic dbg_clk_en;
    logic osc_run;
    logic clkgen_active;
    logic clkgen_standby;
    logic reg_standby;
    logic conv_standby;
    logic pin_hold;
    logic pin_force_reset;
    logic ram_retain;
    logic rti_osc_en;
    logic kbi_active;
    logic periph_reset;
  } smc_pwr_s;
endpackage

module smc_sync
  import smc_pkg::*;
#(
  parameter int W = 11,
  parameter logic [W-1:0] INIT = '0
)(
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, low
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised outputs
);
  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_q[i] <= INIT[i];
          q[i] <= INIT[i];
        end
        else
        begin
          meta_q[i] <= d[i];
          q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule // smc_sync

// ==== smc_ctrl.sv ====
// stop-mode sequencing, power gating and control registers
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps

module smc_ctrl
  import smc_pkg::*;
(
  input wire logic sys_clk, // system clock, 40 MHz
  input wire logic nrst, // async reset, low
  input wire smc_bus_s bus, // register port request
  output logic [SMC_DW-1:0] rdata, // read data, cycle after read
  input wire logic stop_exec, // cpu executes stop, pulse
  input wire logic reset_pin_n, // reset pin, low asserted
  input wire logic irq_pin_n, // interrupt pin, low asserted
  input wire logic [SMC_KBI_W-1:0] kbi_pin_n, // keypad pins, low
  input wire logic rti_toggle, // flips on each periodic wake tick
  input wire logic bgnd_cmd, // background command received, pulse
  input wire logic dbg_go, // leave active debug, pulse
  input wire logic mem_status_cmd, // status memory command, pulse
  output logic mem_status_err, // stop/wait error answer, pulse
  output smc_pwr_s pwr, // clock, regulator, pin controls
  output logic wake_pulse, // wake taken, pulse
  output smc_vec_e wake_vec, // vector fetched on wake
  output logic sys_reset_req, // device reset request, level
  output logic illegal_op_reset // illegal opcode reset, pulse
);
  localparam logic [2:0] RTI_OFF = 3'h0;

  smc_state_e state_q, state_d;
  smc_vec_e vec_d;
  smc_pwr_s pwr_d;
  logic [SMC_DW-1:0] ctrl_q;
  logic [SMC_DW-1:0] kbi_en_q;
  logic dbg_q;
  logic lvd_q;
  logic flag_q;
  logic latch_q;
  logic rti_prev_q;
  logic [10:0] sync_q;
  logic rst_s, irq_s, kbi_s, rti_s, rti_ev;
  logic deep_wake;
  logic stopped;
  logic ack_wr;
  logic [2:0] rate;

  function automatic logic hit(input smc_bus_s b, input logic [3:0] ofs);
    hit = (b.addr == ofs);
  endfunction

  function automatic smc_state_e resolve(input logic power_down_select, input logic partial_power_down_select,
                                         input logic dbg, input logic low_volt_detect_in_stop_enable);
    if (dbg || low_volt_detect_in_stop_enable)
      resolve = SMC_STOP3; // [R07] [R12] [R26]
    else if (!power_down_select)
      resolve = SMC_STOP3; // [R24]
    else if (partial_power_down_select)
      resolve = SMC_STOP2; // [R24]
    else
      resolve = SMC_STOP1; // [R24]
  endfunction

  smc_sync #(
    .W(11),
    .INIT(SMC_SYNC_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d({rti_toggle, kbi_pin_n, irq_pin_n, reset_pin_n}),
    .q(sync_q)
  );

  assign rate = {ctrl_q[SMC_C_RTI_HI], ctrl_q[SMC_C_RTI_MID],
                 ctrl_q[SMC_C_RTI_LO]};
  assign rst_s = !sync_q[0];
  assign irq_s = !sync_q[1];
  assign kbi_s = |(~sync_q[9:2] & kbi_en_q[SMC_KBI_W-1:0]);
  assign rti_s = sync_q[10];
  // tick ignored while rate bits are zero
  assign rti_ev = (rti_s ^ rti_prev_q) && (rate != RTI_OFF); // [R05]
  assign stopped = (state_q == SMC_STOP1) || (state_q == SMC_STOP2)
                   || (state_q == SMC_STOP3);
  assign ack_wr = bus.wr && hit(bus, SMC_OFS_ACK) && bus.wdata[SMC_A_ACK];

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rti_prev_q <= 1'b0;
    else
      rti_prev_q <= rti_s;
  end

  // next mode and wake source
  always_comb
  begin
    state_d = state_q;
    vec_d = SMC_V_NONE;
    deep_wake = 1'b0;
    case (state_q)
      SMC_RUN:
      begin
        if (stop_exec && ctrl_q[SMC_C_STOP_ENTRY_ENABLE])
          state_d = resolve(ctrl_q[SMC_C_PDC], ctrl_q[SMC_C_PARTIAL_POWER_DOWN_SELECT],
                            ctrl_q[SMC_C_DBG], ctrl_q[SMC_C_LOW_VOLT_DETECT_IN_STOP_ENABLE]); // [R26]
      end
      SMC_STOP1:
      begin
        if (rst_s || irq_s)
        begin
          state_d = SMC_RUN;
          vec_d = SMC_V_RESET; // [R17]
          deep_wake = 1'b1;
        end
      end
      SMC_STOP2:
      begin
        if (rst_s || irq_s || rti_ev)
        begin
          state_d = SMC_RUN;
          vec_d = SMC_V_RESET; // [R16]
          deep_wake = 1'b1;
        end
      end
      SMC_STOP3:
      begin
        state_d = SMC_RUN;
        if (rst_s)
          vec_d = SMC_V_RESET; // [R03] [R04]
        else if (irq_s)
          vec_d = SMC_V_IRQ; // [R04]
        else if (kbi_s)
          vec_d = SMC_V_KBI; // [R21]
        else if (rti_ev)
          vec_d = SMC_V_RTI; // [R04] [R05]
        else if (bgnd_cmd && dbg_q)
        begin
          state_d = SMC_DEBUG; // [R09]
          vec_d = SMC_V_DEBUG;
        end
        else
          state_d = SMC_STOP3; // [R02]
      end
      SMC_DEBUG:
      begin
        if (rst_s || dbg_go)
          state_d = SMC_RUN;
      end
      default:
        state_d = SMC_RUN;
    endcase
    if (rst_s && state_q != SMC_STOP3 && stopped)
      vec_d = SMC_V_RESET;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= SMC_RUN;
    else
      state_q <= state_d;
  end

  // override bits caught once, as stop executes
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dbg_q <= 1'b0;
      lvd_q <= 1'b0;
    end
    else if (state_q == SMC_RUN && stop_exec)
    begin
      dbg_q <= ctrl_q[SMC_C_DBG]; // [R06]
      lvd_q <= ctrl_q[SMC_C_LOW_VOLT_DETECT_ENABLE] && ctrl_q[SMC_C_LOW_VOLT_DETECT_IN_STOP_ENABLE]; // [R11]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wake_pulse <= 1'b0;
      wake_vec <= SMC_V_NONE;
    end
    else
    begin
      wake_pulse <= (vec_d != SMC_V_NONE);
      if (vec_d != SMC_V_NONE)
        wake_vec <= vec_d; // [R04]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      illegal_op_reset <= 1'b0;
      sys_reset_req <= 1'b0;
      mem_status_err <= 1'b0;
    end
    else
    begin
      illegal_op_reset <= (state_q == SMC_RUN) && stop_exec
                          && !ctrl_q[SMC_C_STOP_ENTRY_ENABLE]; // [R23]
      sys_reset_req <= rst_s || deep_wake; // [R04] [R16] [R17]
      mem_status_err <= mem_status_cmd && stopped; // [R08]
    end
  end

  // registers return to defaults on reset pin or deep wake
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= SMC_CTRL_RST;
      kbi_en_q <= SMC_KBI_RST;
    end
    else if (rst_s || deep_wake)
    begin
      ctrl_q <= SMC_CTRL_RST; // [R16] [R17]
      kbi_en_q <= SMC_KBI_RST; // [R21]
    end
    else if (bus.wr && hit(bus, SMC_OFS_CTRL))
      ctrl_q <= bus.wdata;
    else if (bus.wr && hit(bus, SMC_OFS_KBI_EN))
      kbi_en_q <= bus.wdata;
  end

  // recovery flag and pin latch: set wins over acknowledge
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flag_q <= 1'b0;
      latch_q <= 1'b0;
    end
    else if (state_q == SMC_STOP2 && deep_wake)
    begin
      flag_q <= 1'b1; // [R25]
      latch_q <= 1'b1; // [R16]
    end
    else if (state_q == SMC_RUN && stop_exec && ctrl_q[SMC_C_STOP_ENTRY_ENABLE]
             && resolve(ctrl_q[SMC_C_PDC], ctrl_q[SMC_C_PARTIAL_POWER_DOWN_SELECT],
                        ctrl_q[SMC_C_DBG], ctrl_q[SMC_C_LOW_VOLT_DETECT_IN_STOP_ENABLE]) == SMC_STOP2)
      latch_q <= 1'b1; // [R15]
    else if (ack_wr)
    begin
      flag_q <= 1'b0; // [R25]
      latch_q <= 1'b0; // [R16]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= '0;
    else if (bus.rd)
    begin
      if (hit(bus, SMC_OFS_CTRL))
        rdata <= ctrl_q;
      else if (hit(bus, SMC_OFS_KBI_EN))
        rdata <= kbi_en_q;
      else if (hit(bus, SMC_OFS_STATUS))
      begin
        rdata <= '0;
        rdata[SMC_S_MODE +: 3] <= state_q;
        rdata[SMC_S_FLAG] <= flag_q;
        rdata[SMC_S_LATCH] <= latch_q;
        rdata[SMC_S_VEC +: 3] <= wake_vec;
      end
      else
        rdata <= '0;
    end
  end

  // power and clock gating per mode
  always_comb
  begin
    pwr_d = '0;
    pwr_d.cpu_clk_en = 1'b1;
    pwr_d.periph_clk_en = 1'b1;
    pwr_d.dbg_clk_en = 1'b1;
    pwr_d.osc_run = 1'b1;
    pwr_d.clkgen_active = 1'b1;
    pwr_d.pin_hold = latch_q; // [R16]
    pwr_d.ram_retain = 1'b1;
    pwr_d.rti_osc_en = (rate != RTI_OFF); // [R05]
    pwr_d.kbi_active = 1'b1;
    pwr_d.periph_reset = deep_wake; // [R19] [R20] [R21]
    if (stopped)
    begin
      pwr_d.cpu_clk_en = 1'b0;
      pwr_d.periph_clk_en = 1'b0; // [R14] [R19]
      pwr_d.dbg_clk_en = dbg_q; // [R06] [R14]
      pwr_d.conv_standby = 1'b1; // [R01] [R20]
      pwr_d.reg_standby = !(dbg_q || lvd_q); // [R22] [R11]
    end
    case (state_q)
      SMC_STOP1:
      begin
        pwr_d.osc_run = 1'b0; // [R18]
        pwr_d.clkgen_active = 1'b0;
        pwr_d.pin_force_reset = 1'b1; // [R15]
        pwr_d.ram_retain = 1'b0; // [R17]
        pwr_d.rti_osc_en = 1'b0;
        pwr_d.kbi_active = 1'b0; // [R21]
      end
      SMC_STOP2:
      begin
        pwr_d.osc_run = 1'b0; // [R18]
        pwr_d.clkgen_active = 1'b0;
        pwr_d.pin_hold = 1'b1; // [R15]
        pwr_d.kbi_active = 1'b0; // [R21]
      end
      SMC_STOP3:
      begin
        if (dbg_q)
          pwr_d.osc_run = 1'b1; // [R10]
        else
        begin
          pwr_d.clkgen_active = 1'b0; // [R01] [R13]
          pwr_d.clkgen_standby = 1'b1; // [R18] [R13]
          pwr_d.osc_run = ctrl_q[SMC_C_KEEP_OSC]; // [R18]
        end
      end
      default:
      begin
        pwr_d.conv_standby = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      pwr <= '0;
    else
      pwr <= pwr_d;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_illegal_stop_reset: assert property ( // [R23]
    (state_q == SMC_RUN && stop_exec && !ctrl_q[SMC_C_STOP_ENTRY_ENABLE])
    |=> (illegal_op_reset && state_q == SMC_RUN))
    else $error("stop without entry enable did not reset");

  a_debug_forces_stop3: assert property ( // [R07]
    (state_q == SMC_RUN && stop_exec && ctrl_q[SMC_C_STOP_ENTRY_ENABLE]
     && ctrl_q[SMC_C_DBG]) |=> (state_q == SMC_STOP3 && dbg_q))
    else $error("debug enable did not force stop3");

  a_detect_forces_stop3: assert property ( // [R12]
    (state_q == SMC_RUN && stop_exec && ctrl_q[SMC_C_STOP_ENTRY_ENABLE]
     && ctrl_q[SMC_C_LOW_VOLT_DETECT_IN_STOP_ENABLE]) |=> (state_q == SMC_STOP3))
    else $error("detect-in-stop did not force stop3");

  a_stop1_select: assert property ( // [R24]
    (state_q == SMC_RUN && stop_exec && ctrl_q[SMC_C_STOP_ENTRY_ENABLE]
     && ctrl_q[SMC_C_PDC] && !ctrl_q[SMC_C_PARTIAL_POWER_DOWN_SELECT] && !ctrl_q[SMC_C_DBG]
     && !ctrl_q[SMC_C_LOW_VOLT_DETECT_IN_STOP_ENABLE]) |=> (state_q == SMC_STOP1)
     ##1 (pwr.pin_force_reset && !pwr.ram_retain))
    else $error("stop1 not selected or pins not reset");

  a_periph_clk_off: assert property ( // [R14]
    stopped |=> (!pwr.periph_clk_en && !pwr.cpu_clk_en))
    else $error("peripheral clock running in stop");

  a_reg_standby: assert property ( // [R22]
    (stopped && !dbg_q && !lvd_q) |=> pwr.reg_standby)
    else $error("regulator not in standby");

  a_flag_held: assert property ( // [R25]
    (flag_q && !ack_wr) |=> flag_q)
    else $error("recovery flag dropped without acknowledge");

  a_stop2_wake: assert property ( // [R16]
    (state_q == SMC_STOP2 ##1 state_q == SMC_RUN)
    |-> (flag_q && pwr.periph_reset && sys_reset_req
         && wake_vec == SMC_V_RESET))
    else $error("stop2 wake did not reset and flag");

  a_status_refused: assert property ( // [R08]
    (mem_status_cmd && stopped) |=> mem_status_err)
    else $error("status command not refused in stop");
endmodule // smc_ctrl

// ==== smc_wake_model.sv ====
// wake pin and periodic tick model for the stop controller
`timescale 1ns/1ps

module smc_wake_model
  import smc_pkg::*;
(
  input wire logic irq_req, // hold interrupt pin low
  input wire logic rst_req, // hold reset pin low
  input wire logic [SMC_KBI_W-1:0] kbi_req, // hold keypad pins low
  input wire logic tick_req, // each change makes one tick
  output logic irq_pin_n, // pulled up when idle
  output logic reset_pin_n, // pulled up when idle
  output logic [SMC_KBI_W-1:0] kbi_pin_n, // pulled up when idle
  output logic rti_toggle // flips once per tick
);
  // pins lag so their edges fall between clock edges
  assign #3 irq_pin_n = ~irq_req;
  assign #3 reset_pin_n = ~rst_req;
  assign #3 kbi_pin_n = ~kbi_req;

  // each change of the request is one tick
  assign #4 rti_toggle = tick_req;
endmodule // smc_wake_model

// ==== tb_top.sv ====
// self-checking bench for the stop-mode controller
`timescale 1ns/1ps

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  $display("wrong value %s exp %h got %h", n, e, g); bad_count++; end end

module tb_top
  import smc_pkg::*;
;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [2:0] st;
    logic [7:0] p8;
  } smc_row_s;

  logic sys_clk, nrst, stop_exec, bgnd_cmd, dbg_go, mem_status_cmd;
  logic irq_req, rst_req, tick_req, irq_pin_n, reset_pin_n, rti_toggle;
  logic [SMC_KBI_W-1:0] kbi_req, kbi_pin_n;
  logic mem_status_err, wake_pulse, sys_reset_req, illegal_op_reset;
  logic [SMC_DW-1:0] rdata, rd_v;
  logic [7:0] p8_now;
  logic deep, fl;
  smc_bus_s bus;
  smc_pwr_s pwr;
  smc_vec_e wake_vec, ev;
  smc_row_s rows[6];
  int bad_count, check_count, n;

  assign p8_now = {pwr.periph_clk_en, pwr.cpu_clk_en, pwr.conv_standby,
    pwr.reg_standby, pwr.pin_force_reset, pwr.ram_retain, pwr.kbi_active,
    pwr.dbg_clk_en};

  smc_wake_model u_pins (.irq_req(irq_req), .rst_req(rst_req),
    .kbi_req(kbi_req), .tick_req(tick_req), .irq_pin_n(irq_pin_n),
    .reset_pin_n(reset_pin_n), .kbi_pin_n(kbi_pin_n),
    .rti_toggle(rti_toggle));

  smc_ctrl DUT (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .stop_exec(stop_exec), .reset_pin_n(reset_pin_n),
    .irq_pin_n(irq_pin_n), .kbi_pin_n(kbi_pin_n), .rti_toggle(rti_toggle),
    .bgnd_cmd(bgnd_cmd), .dbg_go(dbg_go), .mem_status_cmd(mem_status_cmd),
    .mem_status_err(mem_status_err), .pwr(pwr), .wake_pulse(wake_pulse),
    .wake_vec(wake_vec), .sys_reset_req(sys_reset_req),
    .illegal_op_reset(illegal_op_reset));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    @(negedge sys_clk);
    rd_v = rdata;
  endtask

  // 0 stop, 1 background command, 2 leave debug, 3 status command
  task automatic pulse(input int w);
    @(posedge sys_clk);
    case (w)
      0: stop_exec <= 1'b1;
      1: bgnd_cmd <= 1'b1;
      2: dbg_go <= 1'b1;
      default: mem_status_cmd <= 1'b1;
    endcase
    @(posedge sys_clk);
    {stop_exec, bgnd_cmd, dbg_go, mem_status_cmd} <= 4'h0;
  endtask

  // cycles high over k cycles: 0 wake, 1 illegal reset, 2 status error
  task automatic cnt(input int w, input int k);
    n = 0;
    repeat (k)
    begin
      @(negedge sys_clk);
      case (w)
        0: n += (wake_pulse === 1'b1);
        1: n += (illegal_op_reset === 1'b1);
        default: n += (mem_status_err === 1'b1);
      endcase
    end
  endtask

  task automatic wake_wait();
    n = 0;
    while (wake_pulse !== 1'b1 && n < 12)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (wake_pulse !== 1'b1)
    begin
      $display("wrong value wake_pulse exp 1 got %b", wake_pulse);
      bad_count++;
      close_out();
    end
  endtask

  initial
  begin
    #500000;
    $display("wrong value run_time exp done got hung");
    bad_count++;
    close_out();
  end

  initial
  begin
    nrst = 1'b0;
    bus = '0;
    {stop_exec, bgnd_cmd, dbg_go, mem_status_cmd} = 4'h0;
    {irq_req, rst_req, tick_req} = 3'h0;
    kbi_req = 8'h00;
    bad_count = 0;
    check_count = 0;
    rows[0] = '{16'h0001, 3'd3, 8'h36};
    rows[1] = '{16'h0003, 3'd1, 8'h38};
    rows[2] = '{16'h0007, 3'd2, 8'h34};
    rows[3] = '{16'h000f, 3'd3, 8'h27};
    rows[4] = '{16'h0037, 3'd3, 8'h26};
    rows[5] = '{16'h0013, 3'd1, 8'h38};
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      wr(SMC_OFS_CTRL, rows[i].ctrl);
      pulse(0);
      rd(SMC_OFS_STATUS);
      `CHK("state", rows[i].st, rd_v[2:0])
      `CHK("pwr", rows[i].p8, p8_now)
      `CHK("pin_hold", rows[i].st == 3'd2, pwr.pin_hold)
      `CHK("osc", rows[i].ctrl[SMC_C_DBG], pwr.osc_run)
      `CHK("clkgen_sb", rows[i].st == 3'd3 && !rows[i].ctrl[SMC_C_DBG], pwr.clkgen_standby)
      deep = (rows[i].st == 3'd1) || (rows[i].st == 3'd2);
      fl = (rows[i].st == 3'd2);
      ev = deep ? SMC_V_RESET : SMC_V_IRQ;
      @(posedge sys_clk);
      irq_req <= 1'b1;
      wake_wait();
      `CHK("vec", ev, wake_vec)
      `CHK("sys_reset", deep, sys_reset_req)
      `CHK("periph_reset", deep, pwr.periph_reset)
      @(posedge sys_clk);
      irq_req <= 1'b0;
      rd(SMC_OFS_CTRL);
      `CHK("ctrl", deep ? 16'h0000 : rows[i].ctrl, rd_v)
      rd(SMC_OFS_STATUS);
      `CHK("status", {ev, fl, fl, 3'd0}, rd_v[7:0])
      `CHK("clk_back", 1'b1, pwr.periph_clk_en)
      wr(SMC_OFS_ACK, 16'h0001);
      rd(SMC_OFS_STATUS);
      `CHK("ack", 2'b00, rd_v[4:3])
    end
    // stop with entry disabled
    wr(SMC_OFS_CTRL, 16'h0006);
    pulse(0);
    cnt(1, 4);
    `CHK("illegal", 1, n)
    rd(SMC_OFS_STATUS);
    `CHK("state", 3'd0, rd_v[2:0])
    // debug-enabled stop, status command, background wake
    wr(SMC_OFS_CTRL, 16'h000b);
    pulse(0);
    pulse(3);
    cnt(2, 4);
    `CHK("status_err", 1, n)
    `CHK("clkgen", 1'b1, pwr.clkgen_active)
    pulse(1);
    wake_wait();
    `CHK("vec", SMC_V_DEBUG, wake_vec)
    rd(SMC_OFS_STATUS);
    `CHK("state", 3'd4, rd_v[2:0])
    pulse(3);
    cnt(2, 4);
    `CHK("status_err", 0, n)
    pulse(2);
    // keypad wake, only from enabled pins
    wr(SMC_OFS_KBI_EN, 16'h0001);
    wr(SMC_OFS_CTRL, 16'h0201);
    pulse(0);
    @(posedge sys_clk);
    kbi_req <= 8'h02;
    cnt(0, 10);
    `CHK("no_wake", 0, n)
    `CHK("keep_osc", 1'b1, pwr.osc_run)
    `CHK("clkgen_sb", 1'b1, pwr.clkgen_standby)
    @(posedge sys_clk);
    kbi_req <= 8'h01;
    wake_wait();
    `CHK("vec", SMC_V_KBI, wake_vec)
    @(posedge sys_clk);
    kbi_req <= 8'h00;
    // periodic tick ignored at rate zero, reset pin exit
    pulse(0);
    @(posedge sys_clk);
    tick_req <= ~tick_req;
    cnt(0, 10);
    `CHK("no_wake", 0, n)
    `CHK("rti_osc", 1'b0, pwr.rti_osc_en)
    @(posedge sys_clk);
    rst_req <= 1'b1;
    wake_wait();
    `CHK("vec", SMC_V_RESET, wake_vec)
    `CHK("sys_reset", 1'b1, sys_reset_req)
    @(posedge sys_clk);
    rst_req <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(SMC_OFS_CTRL, 16'h0041);
    pulse(0);
    @(posedge sys_clk);
    tick_req <= ~tick_req;
    wake_wait();
    `CHK("vec", SMC_V_RTI, wake_vec)
    `CHK("rti_osc", 1'b1, pwr.rti_osc_en)
    // reset in mid-run, then reset values and unmapped read
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(negedge sys_clk);
    `CHK("pwr_in_reset", 14'h0000, pwr)
    @(posedge sys_clk);
    nrst <= 1'b1;
    for (int a = 0; a < 5; a++)
    begin
      rd(4'(a == 4 ? 15 : a));
      `CHK("reg_reset", 16'h0000, rd_v)
    end
    `CHK("ram_retain", 1'b1, pwr.ram_retain)
    close_out();
  end
endmodule // tb_top
